/* logic/thf_pkg.sv */
package thf_pkg;
	// register indices; byte address on the bus is four times the index
	localparam int unsigned IDX_W = 10;
	localparam logic [9:0] IDX_CTRL_ONE = 10'h110;
	localparam logic [9:0] IDX_SUPPRESS = 10'h111;
	localparam logic [9:0] IDX_CTRL_TWO = 10'h113;
	localparam logic [9:0] IDX_WATERMARK = 10'h187;
	localparam logic [9:0] IDX_EVENTS = 10'h191;
	localparam logic [9:0] IDX_MASK = 10'h1A1;
	localparam logic [9:0] IDX_LIVE = 10'h1B1;
	localparam logic [9:0] IDX_FIFO_DATA = 10'h1B4;

	// control one field positions
	localparam int unsigned CT1_MAP = 4;
	localparam int unsigned CT1_FILL = 3;
	localparam int unsigned CT1_EOM = 2;

	// event and live status field positions
	localparam int unsigned EV_UNDERRUN = 3;
	localparam int unsigned EV_DONE = 2;
	localparam int unsigned EV_BELOW = 1;
	localparam int unsigned EV_NOTFULL = 0;
	localparam int unsigned LIVE_EMPTY = 3;
	localparam int unsigned LIVE_FULL = 2;
	localparam int unsigned LIVE_BELOW = 1;
	localparam int unsigned LIVE_NOTFULL = 0;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [3:0] RESET_NIBBLE = 4'h0;
	localparam logic [1:0] WM_MASK = 2'h3;
	localparam logic [7:0] FLAG_BYTE = 8'h7E;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;
	localparam logic [7:0] ABORT_BYTE = 8'hFE;
	localparam logic [2:0] STUFF_RUN = 3'h5;
	localparam logic [2:0] SPARE_TOP = 3'h4;

	// low watermark thresholds in bytes
	localparam logic [6:0] WM_SEL0 = 7'h04;
	localparam logic [6:0] WM_SEL1 = 7'h10;
	localparam logic [6:0] WM_SEL2 = 7'h20;
	localparam logic [6:0] WM_SEL3 = 7'h30;

	typedef struct packed {
		logic abort_request;
		logic unused_six;
		logic controller_enable;
		logic [4:0] carrier_channel_select;
	} thf_ctrl_two_t;

	// one bit slot offered by the transmit framer
	typedef struct packed {
		logic strobe;
		logic [4:0] timeslot;
		logic [2:0] bit_pos;
		logic spare;
		logic [2:0] spare_index;
	} thf_slot_t;

	typedef enum logic [3:0] {
		TX_FILL = 4'h1,
		TX_DATA = 4'h2,
		TX_CLOSE = 4'h4,
		TX_HOLD = 4'h8
	} thf_tx_state_t;
endpackage

/* logic/thf_top.sv */
// Notes on behaviour
// - abort rising edge flushes FIFO, sends one FEh, then fill until new data.
// - controller works only while its enable bit is one.
// - five-bit channel select picks the carrying timeslot in channel mapping.
// - set suppress bit excludes matching channel bit; bit 7 is channel MSB.
// - in spare-bit mapping, suppress bits 4..0 exclude spare bits four to eight.
// - watermark field 00,01,10,11 selects 4,16,32,48 bytes.
// - below-watermark live bit is one while occupancy is under threshold.
// - FIFO holds 64 bytes; not-full live bit is one while a slot is free.
// - live empty and full bits reflect the current FIFO state.
// - latched bits hold until read, clear on read, set again on new event.
// - writing ones to latched register clears those bits; live bits untouched.
// - FIFO empty before end-of-message sets underrun and sends an abort.
// - message-done event sets once a message has been fully sent.
// - below-watermark event sets on each rising edge of the live condition.
// - not-full event sets on each rising edge of the live not-full condition.
// - each latched event has its own mask bit; one enables; masks reset zero.
// - unmasked event pulls interrupt low until the causing bit is read.
// - fill between packets and after abort is 7Eh or FFh by fill select.
// - mapping select chooses timeslot or spare-bit carriage.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module thf_top #(
	parameter int unsigned FIFO_DEPTH = 64,
	parameter int unsigned FIFO_AW = 6
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire thf_pkg::thf_slot_t framer_slot_i,
	output logic hdlc_bit_o,
	output logic hdlc_valid_o,
	output logic irq_n_o
);
	localparam logic [FIFO_AW:0] DEPTH_COUNT = (FIFO_AW + 1)'(FIFO_DEPTH);

	thf_pkg::thf_ctrl_two_t ctrl_two;
	logic [7:0] ctrl_one;
	logic [7:0] bit_suppress;
	logic [1:0] watermark_sel;
	logic [3:0] event_mask;
	logic [3:0] latched_events;

	logic [8:0] fifo_mem [FIFO_DEPTH];
	logic [FIFO_AW-1:0] wr_ptr;
	logic [FIFO_AW-1:0] rd_ptr;
	logic [FIFO_AW:0] fifo_count;

	thf_pkg::thf_tx_state_t tx_state;
	thf_pkg::thf_tx_state_t next_tx_state;
	logic [7:0] shift_reg;
	logic [7:0] next_shift;
	logic [2:0] bit_cnt;
	logic [2:0] ones_run;
	logic stuff_en;
	logic next_stuff_en;
	logic abort_pend;
	logic abort_prev;
	logic below_prev;
	logic not_full_prev;

	localparam int unsigned IDX_W_LOCAL = thf_pkg::IDX_W;
	logic [IDX_W_LOCAL-1:0] reg_idx;
	logic bus_take;
	logic bus_wr;
	logic bus_rd;
	logic [7:0] rd_byte;
	logic [7:0] live_status;
	logic [6:0] threshold;
	logic fifo_empty_now;
	logic fifo_full_now;
	logic below_watermark_now;
	logic not_full_now;
	logic abort_edge;
	logic fifo_push;
	logic fifo_pop;
	logic slot_hit;
	logic [2:0] spare_bit;
	logic stuff_now;
	logic byte_end;
	logic ev_underrun;
	logic ev_done;
	logic [3:0] ev_set;
	logic [3:0] ev_clr;
	logic [7:0] fill_byte;
	logic [8:0] fifo_head;

	assign reg_idx = wb_adr_i[11:2];
	// a request is taken once; ack follows at the next edge and drops after one cycle
	assign bus_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = bus_take && wb_we_i && wb_sel_i[0];
	assign bus_rd = bus_take && !wb_we_i;

	assign fifo_empty_now = (fifo_count == '0);
	assign fifo_full_now = (fifo_count == DEPTH_COUNT);
	assign not_full_now = !fifo_full_now;
	assign below_watermark_now = (fifo_count < (FIFO_AW + 1)'(threshold));
	assign abort_edge = ctrl_two.abort_request && !abort_prev;
	assign fill_byte = ctrl_one[thf_pkg::CT1_FILL] ? thf_pkg::IDLE_BYTE : thf_pkg::FLAG_BYTE;
	assign fifo_head = fifo_mem[rd_ptr];
	// a write into a full FIFO is dropped; software checks not-full before writing
	assign fifo_push = bus_wr && (reg_idx == thf_pkg::IDX_FIFO_DATA) && !fifo_full_now;

	// threshold decoded every clock, so a new watermark acts on the next compare
	always_comb begin
		case (watermark_sel)
			2'h0: threshold = thf_pkg::WM_SEL0;
			2'h1: threshold = thf_pkg::WM_SEL1;
			2'h2: threshold = thf_pkg::WM_SEL2;
			default: threshold = thf_pkg::WM_SEL3;
		endcase
	end

	// live bits carry no history; only the latched register remembers events
	always_comb begin
		live_status = thf_pkg::RESET_BYTE;
		live_status[thf_pkg::LIVE_EMPTY] = fifo_empty_now;
		live_status[thf_pkg::LIVE_FULL] = fifo_full_now;
		live_status[thf_pkg::LIVE_BELOW] = below_watermark_now;
		live_status[thf_pkg::LIVE_NOTFULL] = not_full_now;
	end

	// which framer bit slot carries HDLC data
	// spare slots above the fifth index never carry data
	assign spare_bit = thf_pkg::SPARE_TOP - framer_slot_i.spare_index;
	always_comb begin
		if (!ctrl_two.controller_enable || !framer_slot_i.strobe) begin
			slot_hit = 1'b0;
		end else if (ctrl_one[thf_pkg::CT1_MAP]) begin
			slot_hit = framer_slot_i.spare && (framer_slot_i.spare_index <= thf_pkg::SPARE_TOP)
				&& !bit_suppress[spare_bit];
		end else begin
			slot_hit = (framer_slot_i.timeslot == ctrl_two.carrier_channel_select)
				&& !bit_suppress[framer_slot_i.bit_pos];
		end
	end

	// the run count outlives a data byte, so five trailing ones are stuffed before the flag
	assign stuff_now = (ones_run == thf_pkg::STUFF_RUN);
	assign byte_end = slot_hit && !stuff_now && (bit_cnt == 3'h7);

	// choose the next byte at each byte boundary
	// no CRC is appended; the closing flag follows the last data byte directly
	always_comb begin
		next_tx_state = tx_state;
		next_shift = fill_byte;
		next_stuff_en = 1'b0;
		fifo_pop = 1'b0;
		ev_underrun = 1'b0;
		ev_done = 1'b0;
		if (abort_pend) begin
			next_shift = thf_pkg::ABORT_BYTE;
			next_tx_state = thf_pkg::TX_FILL;
		end else begin
			case (tx_state)
				thf_pkg::TX_FILL: begin
					if (!fifo_empty_now) begin
						next_shift = thf_pkg::FLAG_BYTE;
						next_tx_state = thf_pkg::TX_DATA;
					end
				end
				thf_pkg::TX_DATA: begin
					if (fifo_empty_now) begin
						ev_underrun = 1'b1;
						next_shift = thf_pkg::ABORT_BYTE;
						next_tx_state = thf_pkg::TX_FILL;
					end else begin
						fifo_pop = 1'b1;
						next_shift = fifo_head[7:0];
						next_stuff_en = 1'b1;
						if (fifo_head[8]) begin
							next_tx_state = thf_pkg::TX_CLOSE;
						end
					end
				end
				thf_pkg::TX_CLOSE: begin
					next_shift = thf_pkg::FLAG_BYTE;
					next_tx_state = thf_pkg::TX_HOLD;
				end
				thf_pkg::TX_HOLD: begin
					// closing flag has just gone out completely
					ev_done = 1'b1;
					if (!fifo_empty_now) begin
						next_stuff_en = 1'b1;
						fifo_pop = 1'b1;
						next_shift = fifo_head[7:0];
						next_tx_state = fifo_head[8] ? thf_pkg::TX_CLOSE : thf_pkg::TX_DATA;
					end else begin
						next_tx_state = thf_pkg::TX_FILL;
					end
				end
				default: next_tx_state = thf_pkg::TX_FILL;
			endcase
		end
	end

	// register writes
	// unused control bits are stored as written; software keeps them zero
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ctrl_one <= thf_pkg::RESET_BYTE;
			ctrl_two <= thf_pkg::thf_ctrl_two_t'(thf_pkg::RESET_BYTE);
			bit_suppress <= thf_pkg::RESET_BYTE;
			watermark_sel <= 2'h0;
			event_mask <= thf_pkg::RESET_NIBBLE;
		end else if (bus_wr) begin
			case (reg_idx)
				thf_pkg::IDX_CTRL_ONE: ctrl_one <= wb_dat_i[7:0];
				thf_pkg::IDX_CTRL_TWO: ctrl_two <= thf_pkg::thf_ctrl_two_t'(wb_dat_i[7:0]);
				thf_pkg::IDX_SUPPRESS: bit_suppress <= wb_dat_i[7:0];
				thf_pkg::IDX_WATERMARK: watermark_sel <= wb_dat_i[1:0] & thf_pkg::WM_MASK;
				thf_pkg::IDX_MASK: event_mask <= wb_dat_i[3:0];
				default: ;
			endcase
		end
	end

	// bus answer
	// reads of the FIFO data port and of unmapped indices return zero
	always_comb begin
		case (reg_idx)
			thf_pkg::IDX_CTRL_ONE: rd_byte = ctrl_one;
			thf_pkg::IDX_CTRL_TWO: rd_byte = ctrl_two;
			thf_pkg::IDX_SUPPRESS: rd_byte = bit_suppress;
			thf_pkg::IDX_WATERMARK: rd_byte = {6'h00, watermark_sel};
			thf_pkg::IDX_EVENTS: rd_byte = {4'h0, latched_events};
			thf_pkg::IDX_MASK: rd_byte = {4'h0, event_mask};
			thf_pkg::IDX_LIVE: rd_byte = live_status;
			default: rd_byte = thf_pkg::RESET_BYTE;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_take;
			if (bus_rd) begin
				wb_dat_o <= {24'h000000, rd_byte};
			end
		end
	end

	// FIFO storage and occupancy; flush wins over push and pop
	// the ninth bit keeps the end-of-message mark with its byte
	always_ff @(posedge sys_clk_i) begin
		if (fifo_push) begin
			fifo_mem[wr_ptr] <= {ctrl_one[thf_pkg::CT1_EOM], wb_dat_i[7:0]};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fifo_count <= '0;
		end else if (abort_edge) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fifo_count <= '0;
		end else begin
			if (fifo_push) begin
				wr_ptr <= wr_ptr + FIFO_AW'(1);
			end
			if (fifo_pop && byte_end) begin
				rd_ptr <= rd_ptr + FIFO_AW'(1);
			end
			case ({fifo_push, fifo_pop && byte_end})
				2'b10: fifo_count <= fifo_count + (FIFO_AW + 1)'(1);
				2'b01: fifo_count <= fifo_count - (FIFO_AW + 1)'(1);
				default: ;
			endcase
		end
	end

	// abort request edge and pending abort byte
	// only a 0-to-1 change of the abort bit counts, so holding it sends one abort
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			abort_prev <= 1'b0;
			abort_pend <= 1'b0;
		end else begin
			abort_prev <= ctrl_two.abort_request;
			abort_pend <= abort_edge || (abort_pend && !byte_end);
		end
	end

	// bit serializer with zero insertion inside messages
	// dropping the enable bit restarts the serializer from a flag byte
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !ctrl_two.controller_enable) begin
			tx_state <= thf_pkg::TX_FILL;
			shift_reg <= thf_pkg::FLAG_BYTE;
			bit_cnt <= 3'h0;
			ones_run <= 3'h0;
			stuff_en <= 1'b0;
			hdlc_bit_o <= 1'b1;
			hdlc_valid_o <= 1'b0;
		end else begin
			hdlc_valid_o <= slot_hit;
			if (slot_hit) begin
				if (stuff_now) begin
					hdlc_bit_o <= 1'b0;
					ones_run <= 3'h0;
				end else begin
					hdlc_bit_o <= shift_reg[0];
					ones_run <= (shift_reg[0] && stuff_en) ? ones_run + 3'h1 : 3'h0;
					bit_cnt <= bit_cnt + 3'h1;
					if (byte_end) begin
						shift_reg <= next_shift;
						tx_state <= next_tx_state;
						stuff_en <= next_stuff_en;
					end else begin
						shift_reg <= {1'b0, shift_reg[7:1]};
					end
				end
			end
		end
	end

	// latched events: hardware set wins over read clear and write-one clear
	// an underrun or message-done event landing on an abort boundary is dropped; the abort has priority
	always_comb begin
		ev_set = thf_pkg::RESET_NIBBLE;
		ev_set[thf_pkg::EV_UNDERRUN] = byte_end && ev_underrun && !abort_pend;
		ev_set[thf_pkg::EV_DONE] = byte_end && ev_done && !abort_pend;
		ev_set[thf_pkg::EV_BELOW] = below_watermark_now && !below_prev;
		ev_set[thf_pkg::EV_NOTFULL] = not_full_now && !not_full_prev;
		ev_clr = thf_pkg::RESET_NIBBLE;
		if (bus_rd && reg_idx == thf_pkg::IDX_EVENTS) begin
			ev_clr = latched_events;
		end else if (bus_wr && reg_idx == thf_pkg::IDX_EVENTS) begin
			ev_clr = wb_dat_i[3:0];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			latched_events <= thf_pkg::RESET_NIBBLE;
			// edge detectors start at one so the empty FIFO after reset raises no event
			below_prev <= 1'b1;
			not_full_prev <= 1'b1;
		end else begin
			latched_events <= (latched_events & ~ev_clr) | ev_set;
			below_prev <= below_watermark_now;
			not_full_prev <= not_full_now;
		end
	end

	// interrupt releases one cycle after the causing bit is read
	// the mask gates the line only; masked events still latch
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			irq_n_o <= 1'b1;
		end else begin
			irq_n_o <= ~|(latched_events & event_mask);
		end
	end
endmodule
`default_nettype wire

/* testbench/tb_thf_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_thf_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0, spare = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h00000000, rdat;
	logic ack, hbit, vld, irq_n;
	logic [7:0] rv;
	logic [15:0] vc, zc;
	thf_pkg::thf_slot_t slot;
	int error_cnt = 0, check_count = 0;
	always #5 clk = ~clk;
	thf_top u_dut (.sys_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.framer_slot_i(slot), .hdlc_bit_o(hbit), .hdlc_valid_o(vld), .irq_n_o(irq_n));
	thf_framer_model u_far (.clk_i(clk), .rst_i(rst), .run_i(run), .spare_mode_i(spare),
		.bit_i(hbit), .valid_i(vld), .slot_o(slot), .valid_cnt_o(vc), .zero_cnt_o(zc));
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'h1;
		adr <= {a, 2'h0};
		wdat <= {24'h000000, d};
		do @(posedge clk); while (ack !== 1'b1);
		rv = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		sel <= 4'h0;
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK("register", e, rv)
	endtask
	task automatic fill(input int n);
		repeat (n) wr(thf_pkg::IDX_FIFO_DATA, 8'h55);
	endtask
	task automatic abort(input logic [7:0] c);
		wr(thf_pkg::IDX_CTRL_TWO, c | 8'h80);
		wr(thf_pkg::IDX_CTRL_TWO, c);
	endtask
	task automatic frame(output logic [15:0] v, output logic [15:0] z);
		logic [15:0] v0, z0;
		v0 = vc;
		z0 = zc;
		repeat (256) @(posedge clk);
		v = vc - v0;
		z = zc - z0;
	endtask
	task automatic t_reset();
		logic [9:0] r[6] = '{thf_pkg::IDX_CTRL_ONE, thf_pkg::IDX_SUPPRESS, thf_pkg::IDX_CTRL_TWO,
			thf_pkg::IDX_WATERMARK, thf_pkg::IDX_EVENTS, thf_pkg::IDX_MASK};
		foreach (r[i]) rdchk(r[i], 8'h00);
		rdchk(thf_pkg::IDX_LIVE, 8'h0B);
		rdchk(10'h3FF, 8'h00);
	endtask
	task automatic t_watermark();
		int th[4] = '{4, 16, 32, 48};
		wr(thf_pkg::IDX_CTRL_TWO, 8'h20);
		for (int w = 0; w < 4; w++) begin
			wr(thf_pkg::IDX_WATERMARK, 8'(w));
			fill(th[w] - 1);
			rdchk(thf_pkg::IDX_LIVE, 8'h03);
			fill(1);
			rdchk(thf_pkg::IDX_LIVE, 8'h01);
			abort(8'h20);
			rdchk(thf_pkg::IDX_LIVE, 8'h0B);
		end
	endtask
	task automatic t_events();
		bus(1'b0, thf_pkg::IDX_EVENTS, 8'h00);
		fill(64);
		rdchk(thf_pkg::IDX_LIVE, 8'h04);
		abort(8'h20);
		`CHK("irq_n", 1'b1, irq_n)
		wr(thf_pkg::IDX_EVENTS, 8'h02);
		rdchk(thf_pkg::IDX_LIVE, 8'h0B);
		rdchk(thf_pkg::IDX_EVENTS, 8'h01);
		rdchk(thf_pkg::IDX_EVENTS, 8'h00);
		wr(thf_pkg::IDX_MASK, 8'h02);
		fill(64);
		abort(8'h20);
		repeat (2) @(posedge clk);
		`CHK("irq_n", 1'b0, irq_n)
		rdchk(thf_pkg::IDX_EVENTS, 8'h03);
		repeat (2) @(posedge clk);
		`CHK("irq_n", 1'b1, irq_n)
	endtask
	task automatic t_channel();
		logic [15:0] v, z;
		logic [31:0] cs[4] = '{32'h08250008, 32'h083F8106, 32'h18201160, 32'h08050000};
		run <= 1'b1;
		// let the one abort byte still pending from earlier drain out first
		repeat (1024) @(posedge clk);
		foreach (cs[i]) begin
			spare <= 1'b0;
			wr(thf_pkg::IDX_CTRL_ONE, cs[i][31:24]);
			spare <= cs[i][28];
			wr(thf_pkg::IDX_SUPPRESS, cs[i][15:8]);
			wr(thf_pkg::IDX_CTRL_TWO, cs[i][23:16]);
			repeat (16) @(posedge clk);
			frame(v, z);
			`CHK("slots", {8'h00, cs[i][7:0]}, v)
			`CHK("zeros", 16'h0000, z)
		end
	endtask
	task automatic t_abort();
		logic [15:0] v, z;
		wr(thf_pkg::IDX_SUPPRESS, 8'h00);
		wr(thf_pkg::IDX_CTRL_ONE, 8'h10);
		spare <= 1'b1;
		wr(thf_pkg::IDX_CTRL_TWO, 8'h20);
		repeat (64) @(posedge clk);
		frame(v, z);
		`CHK("flag zeros", 16'h0028, z)
		wr(thf_pkg::IDX_CTRL_ONE, 8'h18);
		repeat (64) @(posedge clk);
		wr(thf_pkg::IDX_CTRL_TWO, 8'hA0);
		frame(v, z);
		`CHK("abort zeros", 16'h0001, z)
		wr(thf_pkg::IDX_CTRL_TWO, 8'hA0);
		frame(v, z);
		`CHK("held zeros", 16'h0000, z)
		wr(thf_pkg::IDX_CTRL_TWO, 8'h20);
	endtask
	task automatic t_message();
		bus(1'b0, thf_pkg::IDX_EVENTS, 8'h00);
		wr(thf_pkg::IDX_FIFO_DATA, 8'h00);
		repeat (256) @(posedge clk);
		rdchk(thf_pkg::IDX_EVENTS, 8'h08);
		wr(thf_pkg::IDX_CTRL_ONE, 8'h1C);
		wr(thf_pkg::IDX_FIFO_DATA, 8'hA5);
		repeat (256) @(posedge clk);
		rdchk(thf_pkg::IDX_EVENTS, 8'h04);
		rdchk(thf_pkg::IDX_LIVE, 8'h0B);
	endtask
	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_watermark();
		t_events();
		t_channel();
		t_abort();
		t_message();
		print_verdict();
	end
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end
endmodule
`default_nettype wire

/* testbench/thf_framer_model.sv */
`timescale 1ns/10ps
`default_nettype none
module thf_framer_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic spare_mode_i,
	input wire logic bit_i,
	input wire logic valid_i,
	output thf_pkg::thf_slot_t slot_o,
	output logic [15:0] valid_cnt_o,
	output logic [15:0] zero_cnt_o
);
	logic [7:0] pos;
	// a stopped framer parks its slot counter, so no stale slot stays offered
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i)
			pos <= 8'h00;
		else
			pos <= pos + 8'h01;
	end
	always_comb begin
		slot_o.strobe = run_i;
		slot_o.timeslot = pos[7:3];
		slot_o.bit_pos = ~pos[2:0];
		slot_o.spare = spare_mode_i;
		slot_o.spare_index = pos[2:0];
	end
	// counting zeros is enough to tell fill, flag and abort apart
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valid_cnt_o <= 16'h0000;
			zero_cnt_o <= 16'h0000;
		end else if (valid_i) begin
			valid_cnt_o <= valid_cnt_o + 16'h0001;
			zero_cnt_o <= zero_cnt_o + {15'h0000, !bit_i};
		end
	end
endmodule
`default_nettype wire

/* testbench/thf_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module thf_sva (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire thf_pkg::thf_slot_t framer_slot_i,
	input wire logic hdlc_valid_o,
	input wire logic irq_n_o
);
	logic ev_acc;
	// writes to the mask may also release the line, so both count
	assign ev_acc = wb_cyc_i && wb_stb_i && !wb_ack_o && (wb_adr_i[11:2] == thf_pkg::IDX_EVENTS
		|| wb_adr_i[11:2] == thf_pkg::IDX_MASK);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_rd(logic [9:0] a);
		s_take ##0 (!wb_we_i && wb_adr_i[11:2] == a);
	endsequence
	chk_reset_quiet: assert property ($fell(rst_i) |-> irq_n_o && !wb_ack_o && !hdlc_valid_o)
		else $error("outputs not idle after reset");
	chk_ack_next: assert property (s_take |=> wb_ack_o)
		else $error("ack missing");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_live_upper: assert property (s_rd(thf_pkg::IDX_LIVE) |=> wb_dat_o[31:4] == 28'h0)
		else $error("live upper bits set");
	chk_live_flags: assert property (s_rd(thf_pkg::IDX_LIVE) |=>
		wb_dat_o[2] != wb_dat_o[0] && (!wb_dat_o[3] || wb_dat_o[1]))
		else $error("live flags inconsistent");
	chk_event_upper: assert property (s_rd(thf_pkg::IDX_EVENTS) |=> wb_dat_o[31:4] == 28'h0)
		else $error("event upper bits set");
	chk_slot_cause: assert property (hdlc_valid_o |-> $past(framer_slot_i.strobe))
		else $error("bit without slot");
	chk_spare_range: assert property (framer_slot_i.strobe && framer_slot_i.spare
		&& framer_slot_i.spare_index > 3'h4 |=> !hdlc_valid_o)
		else $error("bit in unused spare slot");
	chk_irq_read: assert property ($rose(irq_n_o) |->
		$past(ev_acc) || $past(ev_acc, 2) || $past(ev_acc, 3))
		else $error("interrupt released without access");
endmodule
bind thf_top thf_sva u_sva (.sys_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_dat_o, .wb_ack_o, .framer_slot_i, .hdlc_valid_o, .irq_n_o);
`default_nettype wire
